// ===== src/mcaso_core.sv
// execution of slew, status-bit, subtract, swap and conversion instructions
//
// Contract
// - slew_select 0 follows the configured rate, 1 forces fastest rate.
// - slew instruction takes effect only while the core holds drive right.
// - slew_select resets to normal.
// - slow to fast becomes effective one core clock after execution.
// - fast to slow becomes effective four core clocks after execution.
// - slew opcode is bits 15..1 = 001101011001011, bit 0 is slew_select.
// - status bit write sets one indexed status bit to the given level.
// - status write opcode 00110111000, level bit 4, index bits 3..0.
// - register subtract writes op2 minus op1 into the destination.
// - every subtract updates the six condition flags.
// - register subtract opcode 001010, dest 9..7, bit 6 set, op2, op1.
// - immediate subtract writes op1 minus 4-bit constant, updates flags.
// - immediate subtract opcode 000111, dest 9..7, constant 6..3, op1.
// - byte swap exchanges low and high bytes of the selected register.
// - swap opcode is bits 15..3 = 0011010101100, register in 2..0.
// - convert clears msb if sign flag 0, else negates low bits, sets msb.
// - convert opcode is bits 15..3 = 0011011100110, register in 2..0.
// - signed-to-integer conversion writes the sign flag, replace or xor.
`timescale 1ns/1ns
module mcaso_core import mcaso_pkg::*; #(
  parameter int DW = DATA_W,
  parameter int NREG = NUM_REGS
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic INSTR_VALID,
  input wire logic [15:0] INSTR,
  input wire logic DRIVE_RIGHT,
  input wire logic REG_WR_EN,
  input wire logic [IDX_W-1:0] REG_WR_IDX,
  input wire logic [DW-1:0] REG_WR_DATA,
  input wire logic [IDX_W-1:0] REG_RD_IDX,
  output logic [DW-1:0] REG_RD_DATA,
  output logic SLEW_SELECT,
  output logic SLEW_FAST,
  output logic [15:0] STATUS,
  output logic RESULT_ZERO,
  output logic RESULT_NEG,
  output logic UNSIGNED_BORROW,
  output logic UNSIGNED_CARRY_OUT,
  output logic SIGNED_UNDERFLOW,
  output logic SIGNED_OVERFLOW,
  output logic CONV_SIGN
);

  // ************************************************************
  // decode
  // ************************************************************
  wire logic is_slew;
  wire logic is_srb;
  wire logic is_sub;
  wire logic is_subi;
  wire logic is_swap;
  wire logic is_integer_to_signed_convert;
  wire logic is_toint;
  wire logic slew_take;
  wire logic alu_take;
  wire logic flag_take;
  wire logic [IDX_W-1:0] op1_idx;
  wire logic [IDX_W-1:0] op2_idx;
  wire logic [IDX_W-1:0] dest_idx;
  wire logic [IDX_W-1:0] wr_idx;
  wire logic [SRB_IDX_W-1:0] srb_idx;
  wire logic [IMM_W-1:0] imm;

  assign is_slew = INSTR_VALID &&
    (INSTR[15:SLEW_OP_LSB] == SLEW_PAT);
  assign is_srb = INSTR_VALID &&
    (INSTR[15:SRB_OP_LSB] == SRB_PAT);
  assign is_sub = INSTR_VALID && INSTR[SUB_FLAG_BIT] &&
    (INSTR[15:ALU_OP_LSB] == SUB_PAT);
  assign is_subi = INSTR_VALID &&
    (INSTR[15:ALU_OP_LSB] == SUBI_PAT);
  assign is_swap = INSTR_VALID &&
    (INSTR[15:SEL_OP_LSB] == SWAP_PAT);
  assign is_integer_to_signed_convert = INSTR_VALID &&
    (INSTR[15:SEL_OP_LSB] == INTEGER_TO_SIGNED_CONVERT_PAT);
  assign is_toint = INSTR_VALID &&
    (INSTR[15:TOINT_OP_LSB] == TOINT_PAT);

  assign op1_idx = INSTR[OP1_LSB +: IDX_W];
  assign op2_idx = INSTR[OP2_LSB +: IDX_W];
  assign dest_idx = INSTR[DEST_LSB +: IDX_W];
  assign srb_idx = INSTR[SRB_IDX_LSB +: SRB_IDX_W];
  assign imm = INSTR[IMM_LSB +: IMM_W];

  // without drive right a slew instruction retires as a no-op
  assign slew_take = is_slew && DRIVE_RIGHT;
  assign flag_take = is_sub || is_subi;
  assign alu_take = flag_take || is_swap || is_integer_to_signed_convert || is_toint;
  assign wr_idx = flag_take ? dest_idx : op1_idx;

  // ************************************************************
  // arithmetic register set
  // ************************************************************
  logic [DW-1:0] regs_r [NREG];
  logic cs_r;
  mcaso_alu_if alu_bus ();

  // sub reads op2 as minuend and op1 as subtrahend
  assign alu_bus.op = is_sub ? OP_SUB :
                      is_subi ? OP_SUBI :
                      is_swap ? OP_SWAP :
                      is_integer_to_signed_convert ? OP_INTEGER_TO_SIGNED_CONVERT :
                      is_toint ? OP_TOINT : OP_NONE;
  assign alu_bus.a = is_sub ? regs_r[op2_idx] : regs_r[op1_idx];
  assign alu_bus.b = is_sub ? regs_r[op1_idx] :
                     {{(DW-IMM_W){1'b0}}, imm};
  assign alu_bus.cs_in = cs_r;
  assign alu_bus.cs_rst = INSTR[TOINT_RST_BIT];

  mcaso_alu u_alu (
    .p (alu_bus)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      wire logic alu_hit;
      wire logic ext_hit;
      assign alu_hit = alu_take && (wr_idx == IDX_W'(gi));
      assign ext_hit = REG_WR_EN && (REG_WR_IDX == IDX_W'(gi));
      // an executing instruction beats a load in the same cycle
      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          regs_r[gi] <= REG_RST;
        end else if (alu_hit) begin
          regs_r[gi] <= alu_bus.res;
        end else if (ext_hit) begin
          regs_r[gi] <= REG_WR_DATA;
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cs_r <= CS_RST;
    end else if (is_toint) begin
      cs_r <= alu_bus.cs_out;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      REG_RD_DATA <= REG_RST;
    end else begin
      REG_RD_DATA <= regs_r[REG_RD_IDX];
    end
  end

  assign CONV_SIGN = cs_r;

  // ************************************************************
  // condition flags
  // ************************************************************
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      RESULT_ZERO <= 1'b0;
      RESULT_NEG <= 1'b0;
      UNSIGNED_BORROW <= 1'b0;
      UNSIGNED_CARRY_OUT <= 1'b0;
      SIGNED_UNDERFLOW <= 1'b0;
      SIGNED_OVERFLOW <= 1'b0;
    end else if (flag_take) begin
      RESULT_ZERO <= alu_bus.zero;
      RESULT_NEG <= alu_bus.neg;
      UNSIGNED_BORROW <= alu_bus.uborrow;
      UNSIGNED_CARRY_OUT <= alu_bus.ucarry;
      SIGNED_UNDERFLOW <= alu_bus.sunder;
      SIGNED_OVERFLOW <= alu_bus.sover;
    end
  end

  // ************************************************************
  // status register
  // ************************************************************
  generate
    for (gi = 0; gi < 16; gi++) begin : g_status
      wire logic hit;
      assign hit = is_srb && (srb_idx == SRB_IDX_W'(gi));
      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          STATUS[gi] <= STATUS_RST[gi];
        end else if (hit) begin
          STATUS[gi] <= INSTR[SRB_LVL_BIT];
        end
      end
    end
  endgenerate

  // ************************************************************
  // slew mode
  // ************************************************************
  logic slew_sel_r;
  logic slew_fast_r;
  logic [2:0] slow_cnt_r;
  logic [2:0] slow_cnt_nxt;
  wire logic slew_mismatch;
  wire logic slow_done;

  assign slew_mismatch = (slew_sel_r != slew_fast_r);
  assign slow_done = (slow_cnt_r == SLOW_CNT_LAST);
  assign slow_cnt_nxt = slew_mismatch && !slew_sel_r && !slow_done ?
                        3'(slow_cnt_r + 3'h1) : 3'h0;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      slew_sel_r <= SLEW_SEL_RST;
    end else if (slew_take) begin
      slew_sel_r <= INSTR[SLEW_SEL_BIT];
    end
  end

  // going fast is immediate, going slow lets the gate settle first
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      slew_fast_r <= SLEW_SEL_RST;
      slow_cnt_r <= 3'h0;
    end else begin
      slow_cnt_r <= slow_cnt_nxt;
      if (slew_mismatch && slew_sel_r) begin
        slew_fast_r <= 1'b1;
      end else if (slew_mismatch && slow_done) begin
        slew_fast_r <= 1'b0;
      end
    end
  end

  assign SLEW_SELECT = slew_sel_r;
  assign SLEW_FAST = slew_fast_r;

endmodule : mcaso_core

// ===== src/mcaso_pkg.sv
// constants, opcode patterns and types for the microcore alu/slew/status ops
package mcaso_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int DATA_W = 16;
  localparam int IDX_W = 3;
  localparam int NUM_REGS = 8;
  localparam int SRB_IDX_W = 4;
  localparam int IMM_W = 4;

  // ************************************************************
  // instruction fields and patterns
  // ************************************************************
  localparam int SLEW_OP_LSB = 1;
  localparam logic [14:0] SLEW_PAT = 15'h1acb;
  localparam int SLEW_SEL_BIT = 0;

  localparam int SRB_OP_LSB = 5;
  localparam logic [10:0] SRB_PAT = 11'h1b8;
  localparam int SRB_LVL_BIT = 4;
  localparam int SRB_IDX_LSB = 0;

  localparam int ALU_OP_LSB = 10;
  localparam logic [5:0] SUB_PAT = 6'h0a;
  localparam int SUB_FLAG_BIT = 6;
  localparam logic [5:0] SUBI_PAT = 6'h07;
  localparam int DEST_LSB = 7;
  localparam int OP2_LSB = 3;
  localparam int OP1_LSB = 0;
  localparam int IMM_LSB = 3;

  localparam int SEL_OP_LSB = 3;
  localparam logic [12:0] SWAP_PAT = 13'h06ac;
  localparam logic [12:0] INTEGER_TO_SIGNED_CONVERT_PAT = 13'h06e6;
  localparam int TOINT_OP_LSB = 4;
  localparam logic [11:0] TOINT_PAT = 12'h372;
  localparam int TOINT_RST_BIT = 3;

  // ************************************************************
  // reset values and slew timing
  // ************************************************************
  localparam logic SLEW_SEL_RST = 1'b0;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic CS_RST = 1'b0;
  localparam int SLOW_TO_FAST_CYC = 1;
  localparam int FAST_TO_SLOW_CYC = 4;
  localparam logic [2:0] SLOW_CNT_LAST = 3'(FAST_TO_SLOW_CYC - 1);

  typedef enum logic [2:0] {
    OP_NONE, OP_SUB, OP_SUBI, OP_SWAP, OP_INTEGER_TO_SIGNED_CONVERT, OP_TOINT
  } mcaso_op_e;

endpackage : mcaso_pkg

// ===== src/mcaso_alu_if.sv
// carrier between the core and its datapath
`timescale 1ns/1ns
interface mcaso_alu_if;
  import mcaso_pkg::*;
  mcaso_op_e op;
  logic [15:0] a;
  logic [15:0] b;
  logic cs_in;
  logic cs_rst;
  logic [15:0] res;
  logic zero;
  logic neg;
  logic uborrow;
  logic ucarry;
  logic sunder;
  logic sover;
  logic cs_out;
  modport core (output op, a, b, cs_in, cs_rst,
                input res, zero, neg, uborrow, ucarry, sunder, sover, cs_out);
  modport alu (input op, a, b, cs_in, cs_rst,
               output res, zero, neg, uborrow, ucarry, sunder, sover, cs_out);
endinterface : mcaso_alu_if

// ===== src/mcaso_alu.sv
// combinational datapath: subtract, swap and sign conversions
`timescale 1ns/1ns
module mcaso_alu import mcaso_pkg::*; (
  mcaso_alu_if.alu p
);
  logic [16:0] diff;
  logic [14:0] neg_low;

  // a minus b with borrow in the extra bit
  assign diff = {1'b0, p.a} - {1'b0, p.b};
  assign neg_low = 15'(~p.a[14:0] + 15'h0001);

  always_comb begin
    p.res = p.a;
    p.cs_out = p.cs_in;
    case (p.op)
      OP_SUB, OP_SUBI: begin
        p.res = diff[15:0];
      end
      OP_SWAP: begin
        p.res = {p.a[7:0], p.a[15:8]};
      end
      OP_INTEGER_TO_SIGNED_CONVERT: begin
        if (p.cs_in) begin
          p.res = {1'b1, neg_low};
        end else begin
          p.res = {1'b0, p.a[14:0]};
        end
      end
      OP_TOINT: begin
        if (p.a[15]) begin
          p.res = {1'b0, neg_low};
        end
        // rst form replaces the sign, otherwise it accumulates
        p.cs_out = p.cs_rst ? p.a[15] : (p.cs_in ^ p.a[15]);
      end
      default: begin
        p.res = p.a;
      end
    endcase
  end

  // subtraction flags, only latched by the core on sub/subi
  assign p.zero = (diff[15:0] == 16'h0000);
  assign p.neg = diff[15];
  assign p.uborrow = diff[16];
  // a difference of unsigned values can never exceed the range
  assign p.ucarry = 1'b0;
  assign p.sunder = p.a[15] & ~p.b[15] & ~diff[15];
  assign p.sover = ~p.a[15] & p.b[15] & diff[15];
endmodule : mcaso_alu

// ===== dv/mcaso_sva.sv
// port checker for the alu/slew/status core
`timescale 1ns/1ns
module mcaso_sva import mcaso_pkg::*; (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic INSTR_VALID,
  input wire logic [15:0] INSTR,
  input wire logic DRIVE_RIGHT,
  input wire logic SLEW_SELECT,
  input wire logic SLEW_FAST,
  input wire logic [15:0] STATUS,
  input wire logic RESULT_ZERO,
  input wire logic RESULT_NEG,
  input wire logic UNSIGNED_BORROW,
  input wire logic UNSIGNED_CARRY_OUT,
  input wire logic SIGNED_UNDERFLOW,
  input wire logic SIGNED_OVERFLOW
);
  // ****
  // decode and slew sequences
  // ****
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire logic slew_w = INSTR_VALID && INSTR[15:1] == SLEW_PAT;
  wire logic srb_w = INSTR_VALID && INSTR[15:5] == SRB_PAT;
  wire logic sub_w = INSTR_VALID && (INSTR[15:10] == SUBI_PAT ||
    INSTR[15:10] == SUB_PAT && INSTR[6]);
  wire logic [5:0] flg_w = {RESULT_ZERO, RESULT_NEG, UNSIGNED_BORROW,
    UNSIGNED_CARRY_OUT, SIGNED_UNDERFLOW, SIGNED_OVERFLOW};
  sequence s_to_slow;
    $fell(SLEW_SELECT) && SLEW_FAST;
  endsequence
  sequence s_held_slow;
    s_to_slow ##0 (!SLEW_SELECT)[*5];
  endsequence
  property p_slew_set;
    slew_w && DRIVE_RIGHT |=> SLEW_SELECT == $past(INSTR[0]);
  endproperty
  a_slew_set: assert property (p_slew_set)
    else $error("slew setting not taken");
  property p_slew_deny;
    slew_w && !DRIVE_RIGHT |=> $stable(SLEW_SELECT);
  endproperty
  a_slew_deny: assert property (p_slew_deny)
    else $error("slew changed without drive right");
  property p_rst_val;
    $rose(RST_N) |-> !SLEW_SELECT && !SLEW_FAST;
  endproperty
  a_rst_val: assert property (p_rst_val)
    else $error("slew not normal after reset");
  property p_fast;
    $rose(SLEW_SELECT) |=> SLEW_FAST;
  endproperty
  a_fast: assert property (p_fast)
    else $error("fast rate late");
  property p_slow_hold;
    s_to_slow |-> SLEW_FAST[*4];
  endproperty
  a_slow_hold: assert property (p_slow_hold)
    else $error("slow rate too early");
  property p_slow_drop;
    s_held_slow |-> !SLEW_FAST;
  endproperty
  a_slow_drop: assert property (p_slow_drop)
    else $error("slow rate too late");
  property p_status;
    srb_w |=> STATUS == (($past(STATUS) & ~(16'h1 << $past(INSTR[3:0])))
      | (16'($past(INSTR[4])) << $past(INSTR[3:0])));
  endproperty
  a_status: assert property (p_status)
    else $error("status bit write wrong");
  property p_flags_keep;
    !sub_w |=> $stable(flg_w);
  endproperty
  a_flags_keep: assert property (p_flags_keep)
    else $error("flags moved without subtract");
endmodule : mcaso_sva
bind mcaso_core mcaso_sva mcaso_sva_inst (.CLK, .RST_N, .INSTR_VALID,
  .INSTR, .DRIVE_RIGHT, .SLEW_SELECT, .SLEW_FAST, .STATUS, .RESULT_ZERO,
  .RESULT_NEG, .UNSIGNED_BORROW, .UNSIGNED_CARRY_OUT, .SIGNED_UNDERFLOW,
  .SIGNED_OVERFLOW);

// ===== dv/mcaso_prog.sv
// microcode stream model, one word per call
`timescale 1ns/1ns
module mcaso_prog (
  input wire logic CLK,
  output logic INSTR_VALID,
  output logic [15:0] INSTR
);
  initial begin
    INSTR_VALID = 1'b0;
    INSTR = 16'h0000;
  end
  // idle word is the inverse: a core ignoring valid would misfire
  task automatic run(input logic [15:0] w);
    @(posedge CLK);
    #1;
    INSTR_VALID = 1'b1;
    INSTR = w;
    @(posedge CLK);
    #1;
    INSTR_VALID = 1'b0;
    INSTR = ~w;
  endtask : run
endmodule : mcaso_prog

// ===== dv/mcaso_core_tb.sv
// self-checking bench for the alu/slew/status core
`timescale 1ns/1ns
module mcaso_core_tb;
  import mcaso_pkg::*;
  logic CLK = 1'b0;
  logic RST_N;
  logic DRIVE_RIGHT;
  logic REG_WR_EN;
  logic [2:0] REG_WR_IDX;
  logic [15:0] REG_WR_DATA;
  logic [2:0] REG_RD_IDX;
  logic INSTR_VALID, SLEW_SELECT, SLEW_FAST, CONV_SIGN, RESULT_ZERO;
  logic RESULT_NEG, UNSIGNED_BORROW, UNSIGNED_CARRY_OUT, SIGNED_UNDERFLOW;
  logic SIGNED_OVERFLOW;
  logic [15:0] INSTR, REG_RD_DATA, STATUS, st;
  int num_errors = 0;
  int compares = 0;
  wire logic [15:0] slew = {14'h0, SLEW_SELECT, SLEW_FAST};
  wire logic [15:0] flags = {10'h0, RESULT_ZERO, RESULT_NEG,
    UNSIGNED_BORROW, UNSIGNED_CARRY_OUT, SIGNED_UNDERFLOW, SIGNED_OVERFLOW};
  always #20 CLK = ~CLK;
  mcaso_prog mcaso_prog_inst (.CLK, .INSTR_VALID, .INSTR);
  mcaso_core mcaso_core_inst (.CLK, .RST_N, .INSTR_VALID, .INSTR,
    .DRIVE_RIGHT, .REG_WR_EN, .REG_WR_IDX, .REG_WR_DATA, .REG_RD_IDX,
    .REG_RD_DATA, .SLEW_SELECT, .SLEW_FAST, .STATUS, .RESULT_ZERO,
    .RESULT_NEG, .UNSIGNED_BORROW, .UNSIGNED_CARRY_OUT, .SIGNED_UNDERFLOW,
    .SIGNED_OVERFLOW, .CONV_SIGN);
  // ****
  // access tasks
  // ****
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : step
  task automatic wreg(input logic [2:0] i, input logic [15:0] d);
    step(1);
    REG_WR_EN = 1'b1;
    REG_WR_IDX = i;
    REG_WR_DATA = d;
    step(1);
    REG_WR_EN = 1'b0;
    REG_WR_DATA = ~d;
  endtask : wreg
  task automatic rreg(input logic [2:0] i, input logic [15:0] e);
    REG_RD_IDX = i;
    step(1);
    chk(REG_RD_DATA, e);
  endtask : rreg
  task automatic op(input logic [15:0] w, input logic [2:0] r,
                    input logic [15:0] e, input logic [15:0] f);
    mcaso_prog_inst.run(w);
    chk(flags, f);
    rreg(r, e);
  endtask : op
  task automatic final_report();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  // ****
  // scenarios
  // ****
  initial begin
    RST_N = 1'b0;
    DRIVE_RIGHT = 1'b0;
    REG_WR_EN = 1'b0;
    REG_WR_IDX = 3'h0;
    REG_WR_DATA = 16'h0000;
    REG_RD_IDX = 3'h0;
    step(4);
    RST_N = 1'b1;
    chk(slew, 16'h0);
    chk(STATUS, 16'h0);
    rreg(3'h7, 16'h0);
    mcaso_prog_inst.run(16'h3597);
    chk(slew, 16'h0);
    DRIVE_RIGHT = 1'b1;
    mcaso_prog_inst.run(16'h3597);
    chk(slew, 16'h2);
    step(1);
    chk(slew, 16'h3);
    mcaso_prog_inst.run(16'h3596);
    chk(slew, 16'h1);
    step(3);
    chk(slew, 16'h1);
    step(1);
    chk(slew, 16'h0);
    st = 16'h0;
    for (int i = 0; i < 16; i++) begin
      mcaso_prog_inst.run(16'h3710 | 16'(i));
      st = st | (16'h1 << i);
      chk(STATUS, st);
    end
    mcaso_prog_inst.run(16'h3700);
    mcaso_prog_inst.run(16'h370f);
    chk(STATUS, 16'h7ffe);
    wreg(3'h1, 16'h0005);
    wreg(3'h2, 16'h0003);
    wreg(3'h3, 16'h8000);
    wreg(3'h6, 16'h7fff);
    wreg(3'h7, 16'hffff);
    op(16'h2a51, 3'h4, 16'hfffe, 16'h0018);
    op(16'h1e8b, 3'h5, 16'h7fff, 16'h0002);
    op(16'h2877, 3'h0, 16'h8000, 16'h0019);
    op(16'h1c9a, 3'h1, 16'h0000, 16'h0020);
    op(16'h3564, 3'h4, 16'hfeff, 16'h0020);
    mcaso_prog_inst.run(16'h3728);
    chk({15'h0, CONV_SIGN}, 16'h1);
    op(16'h3736, 3'h6, 16'h8001, 16'h0020);
    mcaso_prog_inst.run(16'h3723);
    chk({15'h0, CONV_SIGN}, 16'h0);
    op(16'h3737, 3'h7, 16'h7fff, 16'h0020);
    final_report();
  end
endmodule : mcaso_core_tb
